// >>> src/wdcsg_consts.svh
`ifndef WDCSG_CONSTS_SVH
`define WDCSG_CONSTS_SVH

// Register indices; byte address is four times the index
`define WDCSG_CSR_IDX 24'hffffb1
`define WDCSG_CNT_IDX 24'hffffb2
`define WDCSG_STS_IDX 24'hffffb3
`define WDCSG_MASK_IDX 24'hffffb4

// Control/status byte layout
`define WDCSG_B_CNT_INH 7
`define WDCSG_B_CNT_WE 6
`define WDCSG_B_REG_INH 5
`define WDCSG_B_REG_WE 4
`define WDCSG_B_ON_INH 3
`define WDCSG_B_ON 2
`define WDCSG_B_FLAG_INH 1
`define WDCSG_B_FLAG 0

// Interrupt status/mask layout
`define WDCSG_EV_OVF 0
`define WDCSG_EV_CNT_REJ 1
`define WDCSG_EV_N 2

// Reset values
`define WDCSG_RST_CNT_WE 1'h0
`define WDCSG_RST_REG_WE 1'h0
`define WDCSG_RST_ON 1'h1
`define WDCSG_RST_FLAG 1'h0
`define WDCSG_RST_MASK 2'h0

// Counter prescale: pclk cycles per count step
`define WDCSG_PRESCALE 8
`define WDCSG_CNT_W 8

`endif

// >>> src/wdcsg_pkg.sv
package wdcsg_pkg;

  typedef enum logic [2:0] {
    WDCSG_SEL_NONE,
    WDCSG_SEL_CSR,
    WDCSG_SEL_CNT,
    WDCSG_SEL_STS,
    WDCSG_SEL_MASK
  } wdcsg_sel_t;

  typedef enum logic {
    WDCSG_IDLE,
    WDCSG_ACK
  } wdcsg_apb_st_t;

endpackage

// >>> src/wdcsg_if.sv
`timescale 1ns/1ps
interface wdcsg_if #(parameter int CNT_W = 8);
  import wdcsg_pkg::*;
  // Register access
  wdcsg_sel_t sel;
  logic wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  // Counter control
  logic run;
  logic load;
  logic clear;
  logic [CNT_W-1:0] load_val;
  logic [CNT_W-1:0] count;
  logic ovf;

  modport apb (output sel, output wr, output wdata, input rdata);
  modport regs (input sel, input wr, input wdata, output rdata,
                output run, output load, output clear, output load_val,
                input count, input ovf);
  modport cnt (input run, input load, input clear, input load_val,
               output count, output ovf);
endinterface

// >>> src/wdcsg_cnt.sv
`timescale 1ns/1ps
`include "wdcsg_consts.svh"
module wdcsg_cnt #(
  parameter int CNT_W = `WDCSG_CNT_W,
  parameter int PRESCALE = `WDCSG_PRESCALE
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control from the register block
  wdcsg_if.cnt bus
);
  import wdcsg_pkg::*;

  localparam int PW = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
  localparam logic [PW-1:0] PLAST = PW'(PRESCALE - 1);
  localparam logic [CNT_W-1:0] CMAX = '1;

  logic [PW-1:0] pre_q, pre_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic ovf_q, ovf_d;
  logic tick;

  // Prescaler only runs while counting, so a halt keeps the phase
  assign tick = bus.run && (pre_q == PLAST);

  always_comb begin
    pre_d = pre_q;
    cnt_d = cnt_q;
    ovf_d = 1'b0;
    if (bus.run) begin
      pre_d = tick ? '0 : pre_q + PW'(1);
    end
    if (bus.clear) begin
      cnt_d = '0;
      pre_d = '0;
    end else if (bus.load) begin
      cnt_d = bus.load_val;
    end else if (tick) begin
      cnt_d = cnt_q + CNT_W'(1);
      ovf_d = (cnt_q == CMAX);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
      cnt_q <= '0;
      ovf_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      ovf_q <= ovf_d;
    end
  end

  assign bus.count = cnt_q;
  assign bus.ovf = ovf_q;

  a_count_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !bus.run && !bus.load && !bus.clear |=> $stable(cnt_q))
    else $error("counter moved while halted");
endmodule

// >>> src/wdcsg_apb.sv
`timescale 1ns/1ps
`include "wdcsg_consts.svh"
module wdcsg_apb #(
  parameter int AW = 32
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Register block side
  wdcsg_if.apb bus
);
  import wdcsg_pkg::*;

  function automatic wdcsg_sel_t decode(input logic [AW-1:0] a);
    if (a == AW'({`WDCSG_CSR_IDX, 2'h0})) begin
      return WDCSG_SEL_CSR;
    end else if (a == AW'({`WDCSG_CNT_IDX, 2'h0})) begin
      return WDCSG_SEL_CNT;
    end else if (a == AW'({`WDCSG_STS_IDX, 2'h0})) begin
      return WDCSG_SEL_STS;
    end else if (a == AW'({`WDCSG_MASK_IDX, 2'h0})) begin
      return WDCSG_SEL_MASK;
    end else begin
      return WDCSG_SEL_NONE;
    end
  endfunction

  wdcsg_apb_st_t st_q, st_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  wdcsg_sel_t sel;

  assign sel = decode(paddr);

  // One wait state: read data is captured, then committed with pready
  always_comb begin
    st_d = st_q;
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    case (st_q)
      WDCSG_IDLE: begin
        if (psel && penable) begin
          st_d = WDCSG_ACK;
          pready_d = 1'b1;
          pslverr_d = (sel == WDCSG_SEL_NONE);
          prdata_d = (!pwrite && sel != WDCSG_SEL_NONE) ? bus.rdata : 32'h0;
        end
      end
      WDCSG_ACK: begin
        st_d = WDCSG_IDLE;
      end
      default: st_d = WDCSG_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= WDCSG_IDLE;
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign bus.sel = sel;
  assign bus.wdata = pwdata;
  // Write commits at the edge where pready is sampled high
  assign bus.wr = pready_q && psel && penable && pwrite && (sel != WDCSG_SEL_NONE);
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
endmodule

// >>> src/wdcsg_top.sv
// Chosen here: register access over APB.
`timescale 1ns/1ps
`include "wdcsg_consts.svh"
// How it works
// - Counter write enable changes by a write only when that write carries 0 in its inhibit; internal reset clears it.
// - Counter writes land only while counter write enable is 1.
// - Register write enable changes by a write only when that write carries 0 in its inhibit; internal reset clears it.
// - On bit and overflow flag change by software only while register write enable is 1.
// - On bit changes by a write only when that write carries 0 in its inhibit.
// - Counter counts up while on bit is 1, holds when it is 0.
// - On bit is set by any reset or an allowed write of 1.
// - On bit is cleared by an allowed write of 0.
// - Overflow flag changes by a write only when that write carries 0 in its inhibit.
// - Counter overflow raises internal reset and sets the overflow flag.
// - Overflow flag cleared by external reset or an allowed write of 0.
// - All four inhibit bits always read as 1.
module wdcsg_top #(
  parameter int AW = 32,
  parameter int CNT_W = `WDCSG_CNT_W,
  parameter int PRESCALE = `WDCSG_PRESCALE
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System
  output logic irq,
  output logic internal_reset
);
  import wdcsg_pkg::*;

  wdcsg_if #(.CNT_W(CNT_W)) bus ();

  wdcsg_apb #(.AW(AW)) u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .bus(bus.apb)
  );

  wdcsg_cnt #(.CNT_W(CNT_W), .PRESCALE(PRESCALE)) u_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .bus(bus.cnt)
  );

  logic counter_write_enable_q, counter_write_enable_d;
  logic reg_write_enable_q, reg_write_enable_d;
  logic watchdog_on_q, watchdog_on_d;
  logic overflow_reset_flag_q, overflow_reset_flag_d;
  logic [`WDCSG_EV_N-1:0] irq_sts_q, irq_sts_d;
  logic [`WDCSG_EV_N-1:0] irq_mask_q, irq_mask_d;
  logic irq_q, irq_d;
  logic int_rst_q, int_rst_d;

  logic wr_csr, wr_cnt, wr_sts, wr_mask;
  logic [7:0] wb;
  logic [`WDCSG_EV_N-1:0] ev;
  logic [7:0] csr_rd;

  assign wr_csr = bus.wr && (bus.sel == WDCSG_SEL_CSR);
  assign wr_cnt = bus.wr && (bus.sel == WDCSG_SEL_CNT);
  assign wr_sts = bus.wr && (bus.sel == WDCSG_SEL_STS);
  assign wr_mask = bus.wr && (bus.sel == WDCSG_SEL_MASK);
  assign wb = bus.wdata[7:0];

  // Control byte; each guarded bit is decided on its own
  always_comb begin
    counter_write_enable_d = counter_write_enable_q;
    reg_write_enable_d = reg_write_enable_q;
    watchdog_on_d = watchdog_on_q;
    overflow_reset_flag_d = overflow_reset_flag_q;
    if (wr_csr) begin
      if (!wb[`WDCSG_B_CNT_INH]) begin
        counter_write_enable_d = wb[`WDCSG_B_CNT_WE];
      end
      if (!wb[`WDCSG_B_REG_INH]) begin
        reg_write_enable_d = wb[`WDCSG_B_REG_WE];
      end
      if (reg_write_enable_q && !wb[`WDCSG_B_ON_INH]) begin
        watchdog_on_d = wb[`WDCSG_B_ON];
      end
      if (reg_write_enable_q && !wb[`WDCSG_B_FLAG_INH]) begin
        overflow_reset_flag_d = wb[`WDCSG_B_FLAG];
      end
    end
    // Internal reset returns control to its reset state; the flag survives it
    // and is set, winning over a clear in the same cycle
    if (bus.ovf) begin
      counter_write_enable_d = `WDCSG_RST_CNT_WE;
      reg_write_enable_d = `WDCSG_RST_REG_WE;
      watchdog_on_d = `WDCSG_RST_ON;
      overflow_reset_flag_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_write_enable_q <= `WDCSG_RST_CNT_WE;
      reg_write_enable_q <= `WDCSG_RST_REG_WE;
      watchdog_on_q <= `WDCSG_RST_ON;
      overflow_reset_flag_q <= `WDCSG_RST_FLAG;
    end else begin
      counter_write_enable_q <= counter_write_enable_d;
      reg_write_enable_q <= reg_write_enable_d;
      watchdog_on_q <= watchdog_on_d;
      overflow_reset_flag_q <= overflow_reset_flag_d;
    end
  end

  // Counter control
  assign bus.run = watchdog_on_q;
  assign bus.load = wr_cnt && counter_write_enable_q && !bus.ovf;
  assign bus.load_val = bus.wdata[CNT_W-1:0];
  assign bus.clear = bus.ovf;

  // Events: overflow, and a counter write refused for lack of enable
  assign ev[`WDCSG_EV_OVF] = bus.ovf;
  assign ev[`WDCSG_EV_CNT_REJ] = wr_cnt && !counter_write_enable_q;

  always_comb begin
    irq_sts_d = irq_sts_q;
    irq_mask_d = irq_mask_q;
    if (wr_sts) begin
      irq_sts_d = irq_sts_q & ~bus.wdata[`WDCSG_EV_N-1:0];
    end
    // Set after clear so a same-cycle event is kept
    irq_sts_d = irq_sts_d | ev;
    if (wr_mask) begin
      irq_mask_d = bus.wdata[`WDCSG_EV_N-1:0];
    end
    irq_d = |(irq_sts_d & irq_mask_d);
    int_rst_d = bus.ovf;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_q <= '0;
      irq_mask_q <= `WDCSG_RST_MASK;
      irq_q <= 1'b0;
      int_rst_q <= 1'b0;
    end else begin
      irq_sts_q <= irq_sts_d;
      irq_mask_q <= irq_mask_d;
      irq_q <= irq_d;
      int_rst_q <= int_rst_d;
    end
  end

  assign irq = irq_q;
  assign internal_reset = int_rst_q;

  // Inhibit positions read as one regardless of what was written
  assign csr_rd = {1'b1, counter_write_enable_q, 1'b1, reg_write_enable_q,
                   1'b1, watchdog_on_q, 1'b1, overflow_reset_flag_q};

  always_comb begin
    bus.rdata = 32'h0;
    if (bus.sel == WDCSG_SEL_CSR) begin
      bus.rdata = {24'h0, csr_rd};
    end else if (bus.sel == WDCSG_SEL_CNT) begin
      bus.rdata = 32'(bus.count);
    end else if (bus.sel == WDCSG_SEL_STS) begin
      bus.rdata = 32'(irq_sts_q);
    end else if (bus.sel == WDCSG_SEL_MASK) begin
      bus.rdata = 32'(irq_mask_q);
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_csr_write;
    wr_csr && !bus.ovf;
  endsequence

  sequence s_guarded_write;
    s_csr_write ##0 reg_write_enable_q;
  endsequence

  sequence s_overflow;
    bus.ovf ##1 int_rst_q;
  endsequence

  sequence s_on_write;
    s_guarded_write ##0 !wb[`WDCSG_B_ON_INH];
  endsequence

  sequence s_flag_write;
    s_guarded_write ##0 !wb[`WDCSG_B_FLAG_INH];
  endsequence

  a_cnt_we_kept: assert property (
    s_csr_write ##0 wb[`WDCSG_B_CNT_INH] |=> $stable(counter_write_enable_q))
    else $error("counter write enable changed despite inhibit");

  a_cnt_we_taken: assert property (
    s_csr_write ##0 !wb[`WDCSG_B_CNT_INH]
    |=> counter_write_enable_q == $past(wb[`WDCSG_B_CNT_WE]))
    else $error("counter write enable not updated");

  a_cnt_load_gate: assert property (
    wr_cnt && counter_write_enable_q && !bus.ovf
    |=> bus.count == $past(bus.wdata[CNT_W-1:0]))
    else $error("enabled counter write not loaded");

  a_cnt_reject_flag: assert property (
    wr_cnt && !counter_write_enable_q |=> irq_sts_q[`WDCSG_EV_CNT_REJ])
    else $error("refused counter write not flagged");

  a_reg_we_kept: assert property (
    s_csr_write ##0 wb[`WDCSG_B_REG_INH] |=> $stable(reg_write_enable_q))
    else $error("register write enable changed despite inhibit");

  a_on_locked: assert property (
    s_csr_write ##0 !reg_write_enable_q
    |=> $stable(watchdog_on_q) && $stable(overflow_reset_flag_q))
    else $error("guarded bits changed while locked");

  a_on_write: assert property (
    s_guarded_write ##0 !wb[`WDCSG_B_ON_INH]
    |=> watchdog_on_q == $past(wb[`WDCSG_B_ON]))
    else $error("on bit not written");

  a_flag_write: assert property (
    s_guarded_write ##0 wb[`WDCSG_B_FLAG_INH] |=> $stable(overflow_reset_flag_q))
    else $error("flag changed despite inhibit");

  a_ovf_effect: assert property (
    bus.ovf |=> overflow_reset_flag_q && watchdog_on_q && int_rst_q ##1 !int_rst_q)
    else $error("overflow did not reset and flag");

  a_ovf_seq: assert property (
    s_overflow |-> !counter_write_enable_q && !reg_write_enable_q)
    else $error("internal reset left enables set");

  // Checked at the bus pins so the whole read path is covered
  a_inhibit_read: assert property (
    pready && psel && !pwrite && bus.sel == WDCSG_SEL_CSR
    |-> prdata[`WDCSG_B_CNT_INH] && prdata[`WDCSG_B_REG_INH] && prdata[`WDCSG_B_ON_INH]
        && prdata[`WDCSG_B_FLAG_INH])
    else $error("inhibit bit read as zero");

  a_irq_level: assert property (
    irq_q == |(irq_sts_q & irq_mask_q))
    else $error("interrupt level disagrees with status and mask");

  a_reg_we_taken: assert property (
    s_csr_write ##0 !wb[`WDCSG_B_REG_INH]
    |=> reg_write_enable_q == $past(wb[`WDCSG_B_REG_WE]))
    else $error("register write enable not updated");

  a_on_kept: assert property (
    s_guarded_write ##0 wb[`WDCSG_B_ON_INH]
    |=> $stable(watchdog_on_q))
    else $error("on bit changed despite inhibit");

  a_on_set: assert property (
    s_on_write ##0 wb[`WDCSG_B_ON]
    |=> watchdog_on_q)
    else $error("allowed write of one did not set on bit");

  a_on_clear: assert property (
    s_on_write ##0 !wb[`WDCSG_B_ON]
    |=> !watchdog_on_q)
    else $error("allowed write of zero did not clear on bit");

  a_on_fall_cause: assert property (
    $fell(watchdog_on_q)
    |-> $past(wr_csr && reg_write_enable_q && !wb[`WDCSG_B_ON_INH]))
    else $error("on bit cleared without an allowed write");

  a_flag_taken: assert property (
    s_flag_write
    |=> overflow_reset_flag_q == $past(wb[`WDCSG_B_FLAG]))
    else $error("allowed flag write not applied");

  a_flag_rise_cause: assert property (
    $rose(overflow_reset_flag_q)
    |-> $past(bus.ovf) || $past(wr_csr && reg_write_enable_q && !wb[`WDCSG_B_FLAG_INH]))
    else $error("flag set without overflow or allowed write");

  a_enables_quiet: assert property (
    !wr_csr && !bus.ovf
    |=> $stable(counter_write_enable_q) && $stable(reg_write_enable_q))
    else $error("enable bit moved without a control write");

  a_refused_hold: assert property (
    wr_cnt && !counter_write_enable_q && !watchdog_on_q && !bus.ovf
    |=> $stable(bus.count))
    else $error("refused counter write moved the count");

  a_count_step: assert property (
    watchdog_on_q && !bus.load && !bus.clear
    |=> bus.count == $past(bus.count) || bus.count == $past(bus.count) + CNT_W'(1))
    else $error("running counter jumped");

  a_halt_hold: assert property (
    !watchdog_on_q && !bus.load && !bus.clear
    |=> $stable(bus.count))
    else $error("halted counter moved");

  a_ovf_at_wrap: assert property (
    bus.ovf
    |-> $past(bus.count) == '1 && bus.count == '0)
    else $error("overflow without a wrap of the count");

  a_ovf_restart: assert property (
    bus.ovf
    |=> bus.count == '0)
    else $error("count not restarted by internal reset");

  a_int_rst_cause: assert property (
    int_rst_q
    |-> $past(bus.ovf))
    else $error("internal reset without overflow");

  a_sts_sticky: assert property (
    !wr_sts
    |=> ($past(irq_sts_q) & ~irq_sts_q) == '0)
    else $error("status bit dropped without a clear");

  a_sts_clear: assert property (
    wr_sts && !(|ev)
    |=> (irq_sts_q & $past(bus.wdata[`WDCSG_EV_N-1:0])) == '0)
    else $error("write of one left a status bit set");

  a_mask_write: assert property (
    wr_mask
    |=> irq_mask_q == $past(bus.wdata[`WDCSG_EV_N-1:0]))
    else $error("mask write not applied");
endmodule

// >>> test/wdcsg_tb.sv
`timescale 1ns/1ps
`include "wdcsg_consts.svh"
module testbench;
  typedef struct {
    logic rd;
    logic [31:0] d;
    logic e;
  } wdcsg_note_t;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic internal_reset;
  wdcsg_note_t q[$];
  wdcsg_note_t mon_t;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int seed = 26;
  int n;
  logic [31:0] v;

  always #4 pclk = ~pclk;

  // Short prescale keeps an overflow within a few hundred cycles
  wdcsg_top #(.AW(32), .CNT_W(8), .PRESCALE(2)) dut_u (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .irq(irq),
    .internal_reset(internal_reset)
  );

  task automatic chk(input logic [31:0] e, input logic [31:0] s, input string nm);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic tend(input string nm);
    $display("test %s finished", nm);
  endtask

  // Called right after a rising edge; leaves one idle cycle behind it
  task automatic xfer(input logic w, input logic [23:0] idx, input logic [31:0] wd,
                      input logic [31:0] ed, input logic ee);
    int k;
    k = 0;
    q.push_back('{~w, ed, ee});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {6'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) chk(32'h1, 32'h0, "pready");
    @(posedge pclk);
  endtask

  task automatic wr(input logic [23:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, {24'h0, d}, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [23:0] idx, input logic [7:0] e);
    xfer(1'b0, idx, 32'h0, {24'h0, e}, 1'b0);
  endtask

  task automatic irqc(input logic e);
    repeat (2) @(posedge pclk);
    chk({31'h0, e}, {31'h0, irq}, "irq");
  endtask

  task automatic wait_irst(input int lim, output int k);
    k = 0;
    while (internal_reset !== 1'b1 && k < lim) begin
      @(posedge pclk);
      k++;
    end
  endtask

  // Response checker: oldest note against each completed transfer
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (q.size() == 0) begin
        chk(32'h0, 32'h1, "response");
      end else begin
        mon_t = q.pop_front();
        if (mon_t.rd) chk(mon_t.d, prdata, "prdata");
        chk({31'h0, mon_t.e}, {31'h0, pslverr}, "pslverr");
      end
    end
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`WDCSG_CSR_IDX, 8'hae);
    rd(`WDCSG_STS_IDX, 8'h00);
    rd(`WDCSG_MASK_IDX, 8'h00);
    irqc(1'b0);
    tend("reset_values");
    wr(`WDCSG_CSR_IDX, 8'ha2);
    rd(`WDCSG_CSR_IDX, 8'hae);
    wr(`WDCSG_CSR_IDX, 8'h9a);
    rd(`WDCSG_CSR_IDX, 8'hbe);
    wr(`WDCSG_CSR_IDX, 8'haa);
    rd(`WDCSG_CSR_IDX, 8'hbe);
    wr(`WDCSG_CSR_IDX, 8'h62);
    rd(`WDCSG_CSR_IDX, 8'hfa);
    tend("guarded_bits");
    v = $random(seed);
    wr(`WDCSG_CNT_IDX, v[7:0]);
    repeat (20) @(posedge pclk);
    rd(`WDCSG_CNT_IDX, v[7:0]);
    wr(`WDCSG_CSR_IDX, 8'h2a);
    rd(`WDCSG_CSR_IDX, 8'hba);
    wr(`WDCSG_CNT_IDX, ~v[7:0]);
    rd(`WDCSG_CNT_IDX, v[7:0]);
    rd(`WDCSG_STS_IDX, 8'h02);
    irqc(1'b0);
    wr(`WDCSG_MASK_IDX, 8'h02);
    irqc(1'b1);
    wr(`WDCSG_STS_IDX, 8'h02);
    rd(`WDCSG_STS_IDX, 8'h00);
    irqc(1'b0);
    tend("counter_gate");
    wr(`WDCSG_CSR_IDX, 8'h6a);
    wr(`WDCSG_CNT_IDX, 8'hf0);
    wr(`WDCSG_CSR_IDX, 8'ha6);
    wait_irst(60, n);
    chk(32'h1, {31'h0, internal_reset}, "internal_reset");
    @(posedge pclk);
    chk(32'h0, {31'h0, internal_reset}, "internal_reset_pulse");
    rd(`WDCSG_CSR_IDX, 8'haf);
    rd(`WDCSG_STS_IDX, 8'h01);
    irqc(1'b0);
    wr(`WDCSG_MASK_IDX, 8'h03);
    irqc(1'b1);
    wr(`WDCSG_STS_IDX, 8'h01);
    irqc(1'b0);
    tend("overflow");
    wr(`WDCSG_CSR_IDX, 8'h9a);
    rd(`WDCSG_CSR_IDX, 8'hbf);
    wr(`WDCSG_CSR_IDX, 8'haa);
    rd(`WDCSG_CSR_IDX, 8'hbf);
    wr(`WDCSG_CSR_IDX, 8'ha8);
    rd(`WDCSG_CSR_IDX, 8'hbe);
    tend("flag_clear");
    xfer(1'b0, 24'h0, 32'h0, 32'h0, 1'b1);
    xfer(1'b1, 24'h0, 32'hffffffff, 32'h0, 1'b1);
    tend("unmapped");
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      wr(`WDCSG_MASK_IDX, {6'h0, v[1:0]});
      rd(`WDCSG_MASK_IDX, {6'h0, v[1:0]});
    end
    tend("mask_random");
    // Counter restarted from zero at the overflow and runs freely
    wait_irst(700, n);
    chk(32'h1, {31'h0, internal_reset}, "internal_reset_again");
    repeat (2) @(posedge pclk);
    rd(`WDCSG_CSR_IDX, 8'haf);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`WDCSG_CSR_IDX, 8'hae);
    rd(`WDCSG_STS_IDX, 8'h00);
    tend("pin_reset");
    test_done();
  end
endmodule
